// File: shared/fead_pkg.sv
// Constants, opcodes, command classes and state codes of the extended
// address decoder.
// Assumes nothing of its surroundings; the capture and top modules use it by scope.
package fead_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Dedicated opcodes that always carry a four-byte address.
   localparam logic [7:0] OP_WIDE_PLAIN_READ = 8'h13;
   localparam logic [7:0] OP_WIDE_FAST_READ = 8'h0c;
   localparam logic [7:0] OP_WIDE_DOUBLE_RATE_READ = 8'h0e;
   localparam logic [7:0] OP_WIDE_DUAL_IO_READ = 8'hbc;
   localparam logic [7:0] OP_WIDE_DUAL_OUT_READ = 8'h3c;
   localparam logic [7:0] OP_WIDE_DUAL_DOUBLE_RATE_READ = 8'hbe;
   localparam logic [7:0] OP_WIDE_QUAD_IO_READ = 8'hec;
   localparam logic [7:0] OP_WIDE_QUAD_OUT_READ = 8'h6c;
   localparam logic [7:0] OP_WIDE_QUAD_DOUBLE_RATE_READ = 8'hee;
   localparam logic [7:0] OP_WIDE_PAGE_PROGRAM = 8'h12;
   localparam logic [7:0] OP_WIDE_QUAD_PAGE_PROGRAM_A = 8'h34;
   localparam logic [7:0] OP_WIDE_QUAD_PAGE_PROGRAM_B = 8'h3e;
   localparam logic [7:0] OP_WIDE_SECTOR_ERASE = 8'h21;
   localparam logic [7:0] OP_WIDE_BLOCK_ERASE_32K = 8'h5c;
   localparam logic [7:0] OP_WIDE_BLOCK_ERASE_64K = 8'hdc;
   localparam logic [7:0] OP_WIDE_SECTOR_RELEASE = 8'h25;
   localparam logic [7:0] OP_WIDE_READ_VOLATILE_LOCK = 8'he0;
   localparam logic [7:0] OP_WIDE_WRITE_VOLATILE_LOCK = 8'he1;
   localparam logic [7:0] OP_WIDE_READ_PERSISTENT_LOCK = 8'he2;
   localparam logic [7:0] OP_WIDE_PROGRAM_PERSISTENT_LOCK = 8'he3;

   ////////////////////////////////////////////////////////////////////////
   // Legacy opcodes whose address width follows the address mode.
   localparam logic [7:0] OP_PLAIN_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_FAST_READ_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_FAST_READ_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_FAST_READ_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_FAST_READ_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_FAST_READ_DOUBLE_RATE = 8'h0d;
   localparam logic [7:0] OP_DUAL_IO_DOUBLE_RATE_READ = 8'hbd;
   localparam logic [7:0] OP_QUAD_IO_DOUBLE_RATE_READ = 8'hed;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_QUAD_PAGE_PROGRAM_A = 8'h32;
   localparam logic [7:0] OP_QUAD_PAGE_PROGRAM_B = 8'h38;
   localparam logic [7:0] OP_SECTOR_ERASE_A = 8'hd7;
   localparam logic [7:0] OP_SECTOR_ERASE_B = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_BLOCK_ERASE_64K = 8'hd8;
   localparam logic [7:0] OP_SECTOR_RELEASE = 8'h26;
   localparam logic [7:0] OP_READ_VOLATILE_LOCK = 8'hfa;
   localparam logic [7:0] OP_WRITE_VOLATILE_LOCK = 8'hfb;
   localparam logic [7:0] OP_READ_PERSISTENT_LOCK = 8'hfc;
   localparam logic [7:0] OP_PROGRAM_PERSISTENT_LOCK = 8'hfd;

   ////////////////////////////////////////////////////////////////////////
   // Bank register layout and reset value, and the last array address.
   localparam int BANK_WIDE_BIT = 7;
   localparam int BANK_SEL_BIT = 0;
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [7:0] BANK_WRITE_MASK = 8'h81;
   localparam logic [31:0] ARRAY_LAST = 32'h01ffffff;

   ////////////////////////////////////////////////////////////////////////
   // Frame lengths in whole bytes and bit counter limits.
   localparam logic [2:0] HDR_BYTES = 3'd5;
   localparam logic [2:0] LEN_NARROW = 3'd4;
   localparam logic [2:0] LEN_WIDE = 3'd5;
   localparam logic [2:0] LEN_BANK_WRITE = 3'd2;
   localparam logic [2:0] LEN_OPCODE = 3'd1;
   localparam logic [2:0] BYTE_CNT_MAX = 3'd7;
   localparam logic [2:0] BIT_LAST = 3'd7;
   localparam logic [2:0] BIT_FIRST = 3'd1;

   ////////////////////////////////////////////////////////////////////////
   // Command classes reported with each accepted command.
   typedef enum logic [2:0] {
      CLS_NONE = 3'h0,
      CLS_READ = 3'h1,
      CLS_PROGRAM = 3'h2,
      CLS_ERASE = 3'h3,
      CLS_LOCK = 3'h4,
      CLS_MODE = 3'h5
   } fead_class_t;

   // Decoder states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EVAL = 2'b10
   } fead_state_t;

endpackage

// File: shared/fead_link_if.sv
// Carrier between the serial-clock capture logic and the core decoder.
// Assumes the capture side writes only on the serial clock and the core
// side reads only after the frame has ended.
`timescale 1ns/1ns
`default_nettype none
interface fead_link_if;
   logic [7:0] byte_q [0:4];
   logic [2:0] byte_cnt_q;
   logic [2:0] bit_cnt_q;

   modport cap (output byte_q, output byte_cnt_q, output bit_cnt_q);
   modport core (input byte_q, input byte_cnt_q, input bit_cnt_q);
endinterface
`default_nettype wire

// File: core/fead_link_capture.sv
// Serial-clock side: shifts in the opcode and header bytes of a frame.
// Assumes the host raises chip select between frames; the serial clock
// may stand still outside frames.
`timescale 1ns/1ns
`default_nettype none
module fead_link_capture (
   input wire logic sck, // Serial clock from the host.
   input wire logic ce_n, // Chip select, active low.
   input wire logic si, // Serial data in, sampled on rising edges.
   fead_link_if.cap lnk // Captured bytes towards the core.
);

   logic first_q;
   logic [6:0] shift_q;
   logic [7:0] full_byte;

   ////////////////////////////////////////////////////////////////////////
   // Marks the next edge as the first of a frame; set by chip select high.
   always_ff @(posedge sck or posedge ce_n) begin
      if (ce_n) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   // Byte formed by the bit arriving now, most significant bit first.
   assign full_byte = {shift_q, si};

   // Bit shifter and bit counter within the current byte.
   always_ff @(posedge sck) begin
      if (first_q) begin
         shift_q <= {6'h00, si};
         lnk.bit_cnt_q <= fead_pkg::BIT_FIRST;
      end else begin
         shift_q <= full_byte[6:0];
         lnk.bit_cnt_q <= lnk.bit_cnt_q + 3'd1;
      end
   end

   // Stores completed header bytes and counts whole bytes, saturating.
   always_ff @(posedge sck) begin
      if (first_q) begin
         lnk.byte_cnt_q <= 3'd0;
      end else if (lnk.bit_cnt_q == fead_pkg::BIT_LAST) begin
         if (lnk.byte_cnt_q < fead_pkg::HDR_BYTES) begin
            lnk.byte_q[lnk.byte_cnt_q] <= full_byte;
         end
         if (lnk.byte_cnt_q != fead_pkg::BYTE_CNT_MAX) begin
            lnk.byte_cnt_q <= lnk.byte_cnt_q + 3'd1;
         end
      end
   end

endmodule
`default_nettype wire

// File: core/fead_top.sv
// Extended address decoder: opcode width selection and bank extension.
// Assumes a host drives chip select, serial clock and serial data, and that
// chip select stays high for at least four core clock periods between frames.
//
// Summary of operation
// - Dedicated opcodes always take a four-byte address, whatever the mode.
// - 13h plain, 0Ch fast, 0Eh double-rate single-wire wide reads.
// - BCh dual IO, 3Ch dual out, BEh dual IO double-rate wide reads.
// - ECh quad IO, 6Ch quad out, EEh quad IO double-rate wide reads.
// - 12h program, 34h/3Eh quad program, 21h sector erase, all wide.
// - 5Ch and DCh block erases, 25h sector release, all wide.
// - E0 to E3 are wide volatile and persistent lock accesses.
// - Wide bit 7 of the bank register forces four-byte legacy addresses.
// - Enter-wide-mode command takes effect only while the wide bit is 0.
// - Legacy reads take three or four address bytes per the mode.
// - Legacy program and erase opcodes follow the address mode too.
// - 26h and FA to FD also follow the address mode.
// - Three-byte addresses get their top byte from the bank register.
// - Bank extension applies to reads, programs and erases alike.
// - Bank register is volatile and resets to bank 0.
// - Reads run on across bank boundaries without added delay.
// - Bank register forms only the start address and is never advanced.
// - Bank bit 0 picks the lower or the upper 16 Mbyte bank.
// - Each frame opens with an opcode; address goes high byte first.
// - Frames not ending on a whole byte are ignored.
`timescale 1ns/1ns
`default_nettype none
module fead_top #(
   parameter logic [7:0] OP_ENTER_WIDE = 8'hb7, // Enter wide address mode.
   parameter logic [7:0] OP_EXIT_WIDE = 8'he9, // Leave wide address mode.
   parameter logic [7:0] OP_BANK_WRITE = 8'h17 // Write the bank register.
) (
   input wire logic CORE_CLK, // Core clock, 20 MHz.
   input wire logic RESET_N, // Synchronous reset, active low.
   input wire logic SCK, // Serial clock from the host.
   input wire logic CE_N, // Chip select from the host, active low.
   input wire logic SI, // Serial data from the host.
   input wire logic RD_NEXT, // Array logic asks for the next read byte.
   output logic CMD_VALID, // One-cycle pulse: command accepted.
   output logic [7:0] CMD_OPCODE, // Opcode of the accepted command.
   output logic [2:0] CMD_CLASS, // Class of the accepted command.
   output logic CMD_WIDE, // Command carried a four-byte address.
   output logic [31:0] CMD_ADDR, // Full start address of the command.
   output logic CMD_DROP, // One-cycle pulse: frame ignored.
   output logic [31:0] RD_ADDR, // Current sequential read address.
   output logic [7:0] BANK_REG, // Bank register contents.
   output logic WIDE_MODE // Enter-wide-mode state.
);

   fead_link_if lnk ();

   logic ce_meta_q;
   logic ce_sync_q;
   logic ce_prev_q;
   logic frame_end;
   fead_pkg::fead_state_t state_q;
   logic [7:0] bank_q;
   logic wide_mode_q;
   logic [7:0] op;
   logic aligned;
   logic dedicated;
   logic legacy;
   fead_pkg::fead_class_t cls;
   logic use_wide;
   logic [2:0] need_bytes;
   logic addr_ok;
   logic [31:0] start_addr;

   ////////////////////////////////////////////////////////////////////////
   // Serial-clock capture of the frame header.
   fead_link_capture u_capture (
      .sck(SCK),
      .ce_n(CE_N),
      .si(SI),
      .lnk(lnk)
   );

   ////////////////////////////////////////////////////////////////////////
   // Chip select crosses into the core domain through two flip-flops.
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         ce_meta_q <= 1'b1;
         ce_sync_q <= 1'b1;
         ce_prev_q <= 1'b1;
      end else begin
         ce_meta_q <= CE_N;
         ce_sync_q <= ce_meta_q;
         ce_prev_q <= ce_sync_q;
      end
   end

   // A rising synchronised chip select ends a frame; captured bytes are
   // quiet from then on because the serial clock stands still.
   assign frame_end = ce_sync_q && !ce_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // Opcode classification into dedicated wide and mode-following groups.
   assign op = lnk.byte_q[0];

   always_comb begin
      dedicated = 1'b0;
      legacy = 1'b0;
      cls = fead_pkg::CLS_NONE;
      case (op)
         fead_pkg::OP_WIDE_PLAIN_READ,
         fead_pkg::OP_WIDE_FAST_READ,
         fead_pkg::OP_WIDE_DOUBLE_RATE_READ: begin
            dedicated = 1'b1;
            cls = fead_pkg::CLS_READ;
         end
         fead_pkg::OP_WIDE_DUAL_IO_READ,
         fead_pkg::OP_WIDE_DUAL_OUT_READ,
         fead_pkg::OP_WIDE_DUAL_DOUBLE_RATE_READ: begin
            dedicated = 1'b1;
            cls = fead_pkg::CLS_READ;
         end
         fead_pkg::OP_WIDE_QUAD_IO_READ,
         fead_pkg::OP_WIDE_QUAD_OUT_READ,
         fead_pkg::OP_WIDE_QUAD_DOUBLE_RATE_READ: begin
            dedicated = 1'b1;
            cls = fead_pkg::CLS_READ;
         end
         fead_pkg::OP_WIDE_PAGE_PROGRAM,
         fead_pkg::OP_WIDE_QUAD_PAGE_PROGRAM_A,
         fead_pkg::OP_WIDE_QUAD_PAGE_PROGRAM_B: begin
            dedicated = 1'b1;
            cls = fead_pkg::CLS_PROGRAM;
         end
         fead_pkg::OP_WIDE_SECTOR_ERASE,
         fead_pkg::OP_WIDE_BLOCK_ERASE_32K,
         fead_pkg::OP_WIDE_BLOCK_ERASE_64K: begin
            dedicated = 1'b1;
            cls = fead_pkg::CLS_ERASE;
         end
         fead_pkg::OP_WIDE_SECTOR_RELEASE,
         fead_pkg::OP_WIDE_READ_VOLATILE_LOCK,
         fead_pkg::OP_WIDE_WRITE_VOLATILE_LOCK,
         fead_pkg::OP_WIDE_READ_PERSISTENT_LOCK,
         fead_pkg::OP_WIDE_PROGRAM_PERSISTENT_LOCK: begin
            dedicated = 1'b1;
            cls = fead_pkg::CLS_LOCK;
         end
         fead_pkg::OP_PLAIN_READ,
         fead_pkg::OP_FAST_READ,
         fead_pkg::OP_FAST_READ_DUAL_IO,
         fead_pkg::OP_FAST_READ_DUAL_OUT,
         fead_pkg::OP_FAST_READ_QUAD_IO,
         fead_pkg::OP_FAST_READ_QUAD_OUT,
         fead_pkg::OP_FAST_READ_DOUBLE_RATE,
         fead_pkg::OP_DUAL_IO_DOUBLE_RATE_READ,
         fead_pkg::OP_QUAD_IO_DOUBLE_RATE_READ: begin
            legacy = 1'b1;
            cls = fead_pkg::CLS_READ;
         end
         fead_pkg::OP_PAGE_PROGRAM,
         fead_pkg::OP_QUAD_PAGE_PROGRAM_A,
         fead_pkg::OP_QUAD_PAGE_PROGRAM_B: begin
            legacy = 1'b1;
            cls = fead_pkg::CLS_PROGRAM;
         end
         fead_pkg::OP_SECTOR_ERASE_A,
         fead_pkg::OP_SECTOR_ERASE_B,
         fead_pkg::OP_BLOCK_ERASE_32K,
         fead_pkg::OP_BLOCK_ERASE_64K: begin
            legacy = 1'b1;
            cls = fead_pkg::CLS_ERASE;
         end
         fead_pkg::OP_SECTOR_RELEASE,
         fead_pkg::OP_READ_VOLATILE_LOCK,
         fead_pkg::OP_WRITE_VOLATILE_LOCK,
         fead_pkg::OP_READ_PERSISTENT_LOCK,
         fead_pkg::OP_PROGRAM_PERSISTENT_LOCK: begin
            legacy = 1'b1;
            cls = fead_pkg::CLS_LOCK;
         end
         default: begin
            if (op == OP_ENTER_WIDE || op == OP_EXIT_WIDE ||
                op == OP_BANK_WRITE) begin
               cls = fead_pkg::CLS_MODE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Address width and frame length check.
   assign use_wide = dedicated ||
      (legacy && (bank_q[fead_pkg::BANK_WIDE_BIT] || wide_mode_q));

   assign aligned = (lnk.bit_cnt_q == 3'd0) && // Wraps to zero per byte.
      (lnk.byte_cnt_q != 3'd0);

   always_comb begin
      need_bytes = fead_pkg::LEN_OPCODE;
      if (dedicated || legacy) begin
         need_bytes = use_wide ? fead_pkg::LEN_WIDE : fead_pkg::LEN_NARROW;
      end else if (op == OP_BANK_WRITE) begin
         need_bytes = fead_pkg::LEN_BANK_WRITE;
      end
   end

   assign addr_ok = aligned && (lnk.byte_cnt_q >= need_bytes);

   // Start address, high byte first; the bank supplies the top byte whenever
   // the command takes three address bytes, even if more bytes were sent.
   always_comb begin
      if (use_wide) begin
         start_addr = {lnk.byte_q[1], lnk.byte_q[2], lnk.byte_q[3],
                       lnk.byte_q[4]};
      end else begin
         start_addr = {7'h00, bank_q[fead_pkg::BANK_SEL_BIT],
                       lnk.byte_q[1], lnk.byte_q[2],
                       lnk.byte_q[3]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoder state: a frame end leads to one evaluation cycle.
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         state_q <= fead_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            fead_pkg::ST_IDLE: begin
               if (frame_end) begin
                  state_q <= fead_pkg::ST_EVAL;
               end
            end
            fead_pkg::ST_EVAL: begin
               state_q <= fead_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Bank register and wide mode; volatile, cleared at reset.
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         bank_q <= fead_pkg::BANK_RESET;
         wide_mode_q <= 1'b0;
      end else if (state_q == fead_pkg::ST_EVAL && addr_ok) begin
         if (op == OP_BANK_WRITE) begin
            bank_q <= lnk.byte_q[1] & fead_pkg::BANK_WRITE_MASK;
         end else if (op == OP_ENTER_WIDE &&
                      !bank_q[fead_pkg::BANK_WIDE_BIT]) begin
            wide_mode_q <= 1'b1;
         end else if (op == OP_EXIT_WIDE) begin
            wide_mode_q <= 1'b0;
         end
      end
   end

   // Command report towards the array logic.
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         CMD_VALID <= 1'b0;
         CMD_DROP <= 1'b0;
         CMD_OPCODE <= 8'h00;
         CMD_CLASS <= fead_pkg::CLS_NONE;
         CMD_WIDE <= 1'b0;
         CMD_ADDR <= 32'h00000000;
      end else begin
         CMD_VALID <= 1'b0;
         CMD_DROP <= 1'b0;
         if (state_q == fead_pkg::ST_EVAL) begin
            if (addr_ok && cls != fead_pkg::CLS_NONE) begin
               CMD_VALID <= 1'b1;
               CMD_OPCODE <= op;
               CMD_CLASS <= cls;
               CMD_WIDE <= use_wide;
               CMD_ADDR <= (dedicated || legacy) ? start_addr : 32'h00000000;
            end else begin
               CMD_DROP <= 1'b1;
            end
         end
      end
   end

   // Sequential read address; steps past bank edges, stops at array end,
   // and never writes back into the bank register.
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         RD_ADDR <= 32'h00000000;
      end else if (state_q == fead_pkg::ST_EVAL && addr_ok &&
                   cls == fead_pkg::CLS_READ) begin
         RD_ADDR <= start_addr;
      end else if (RD_NEXT && RD_ADDR != fead_pkg::ARRAY_LAST) begin
         RD_ADDR <= RD_ADDR + 32'h00000001;
      end
   end

   // Visible copies of the mode state.
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         BANK_REG <= fead_pkg::BANK_RESET;
         WIDE_MODE <= 1'b0;
      end else begin
         BANK_REG <= bank_q;
         WIDE_MODE <= wide_mode_q;
      end
   end

endmodule
`default_nettype wire

// File: testbench/fead_host_model.sv
// Host-side model: drives chip select, serial clock and serial data.
// Assumes mode 0 framing and a 15 ns serial clock that runs only in frames.
`timescale 1ns/1ns
`default_nettype none
module fead_host_model (
   output logic sck, // Serial clock, low outside frames.
   output logic ce_n, // Chip select, active low.
   output logic si // Serial data towards the decoder.
);
   // Idle levels; the data line shows no stale bit between frames.
   initial begin
      sck = 1'b0;
      ce_n = 1'b1;
      si = 1'b1;
   end

   // Sends the top nbits of d, most significant bit first, then releases.
   task automatic send(input logic [39:0] d, input int nbits);
      int i;
      #250;
      ce_n = 1'b0;
      for (i = 39; i > 39 - nbits; i--) begin
         #4 si = d[i];
         #4 sck = 1'b1;
         #7 sck = 1'b0;
      end
      #4 ce_n = 1'b1;
      si = ~si;
   endtask
endmodule
`default_nettype wire

// File: testbench/fead_checker.sv
// Concurrent checks on the ports of the extended address decoder.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module fead_checker (
   input wire logic CORE_CLK, // Core clock.
   input wire logic RESET_N, // Synchronous reset, active low.
   input wire logic SCK, // Serial clock.
   input wire logic CE_N, // Chip select.
   input wire logic SI, // Serial data.
   input wire logic RD_NEXT, // Read step request.
   input wire logic CMD_VALID, // Command accepted.
   input wire logic [7:0] CMD_OPCODE, // Accepted opcode.
   input wire logic [2:0] CMD_CLASS, // Accepted class.
   input wire logic CMD_WIDE, // Four address bytes used.
   input wire logic [31:0] CMD_ADDR, // Start address.
   input wire logic CMD_DROP, // Frame ignored.
   input wire logic [31:0] RD_ADDR, // Sequential read address.
   input wire logic [7:0] BANK_REG, // Bank register.
   input wire logic WIDE_MODE // Wide mode state.
);
   localparam logic [31:0] LAST = 32'h01ffffff;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   ////////////////////////////////////////////////////////////////////////
   // A step taken with no command load in the following cycle.
   sequence step_s;
      RD_NEXT && RD_ADDR != LAST ##1 !CMD_VALID;
   endsequence
   sequence stuck_s;
      RD_NEXT && RD_ADDR == LAST ##1 !CMD_VALID;
   endsequence

   ded_wide_a: assert property (CMD_VALID && CMD_OPCODE inside
      {8'h13, 8'h0c, 8'h0e, 8'hbc, 8'h3c, 8'hbe, 8'hec, 8'h6c, 8'hee,
      8'h12, 8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc, 8'h25, 8'he0, 8'he1,
      8'he2, 8'he3} |-> CMD_WIDE) else $error("dedicated opcode not wide");
   ext_forces_a: assert property (CMD_VALID && BANK_REG[7] &&
      CMD_CLASS inside {[3'h1:3'h4]} |-> CMD_WIDE)
      else $error("wide bit set but narrow address");
   bank_top_a: assert property (CMD_VALID && !CMD_WIDE &&
      CMD_CLASS inside {[3'h1:3'h4]} |-> CMD_ADDR[31:24] ==
      {7'h0, BANK_REG[0]}) else $error("narrow top byte not from bank");
   bank_reset_a: assert property (disable iff (1'b0)
      !RESET_N |=> BANK_REG == 8'h00 && !WIDE_MODE)
      else $error("bank or mode not cleared by reset");
   step_next_a: assert property (step_s |->
      RD_ADDR == $past(RD_ADDR) + 32'h1) else $error("read step lost");
   step_stick_a: assert property (stuck_s |-> RD_ADDR == LAST)
      else $error("read address ran past array end");
   bank_steady_a: assert property ($changed(BANK_REG) |->
      $past(CMD_VALID) || $past(CMD_VALID, 2) || $past(CMD_VALID, 3))
      else $error("bank changed without a command");
   bank_bits_a: assert property ((BANK_REG & 8'h7e) == 8'h00)
      else $error("unused bank bits set");
   pulse_excl_a: assert property (CMD_DROP |-> !CMD_VALID ##1
      !CMD_DROP) else $error("drop pulse malformed");
   rd_load_a: assert property (CMD_VALID && CMD_CLASS == 3'h1 |->
      RD_ADDR == CMD_ADDR) else $error("read address not loaded");
   mode_rise_a: assert property ($rose(WIDE_MODE) |->
      !BANK_REG[7]) else $error("wide mode entered with wide bit set");
endmodule

bind fead_top fead_checker u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
   .SCK(SCK), .CE_N(CE_N), .SI(SI), .RD_NEXT(RD_NEXT),
   .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE), .CMD_CLASS(CMD_CLASS),
   .CMD_WIDE(CMD_WIDE), .CMD_ADDR(CMD_ADDR), .CMD_DROP(CMD_DROP),
   .RD_ADDR(RD_ADDR), .BANK_REG(BANK_REG), .WIDE_MODE(WIDE_MODE));
`default_nettype wire

// File: testbench/test_flash_extended_address_decode.sv
// Self-checking bench for the extended address decoder.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module test_flash_extended_address_decode;
   localparam logic [31:0] ADR = 32'h01234567;
   logic CORE_CLK, RESET_N, RD_NEXT, SCK, CE_N, SI;
   logic CMD_VALID, CMD_WIDE, CMD_DROP, WIDE_MODE;
   logic [7:0] CMD_OPCODE, BANK_REG;
   logic [2:0] CMD_CLASS;
   logic [31:0] CMD_ADDR, RD_ADDR;
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [7:0] ded [20] = '{8'h13, 8'h0c, 8'h0e, 8'hbc, 8'h3c, 8'hbe,
      8'hec, 8'h6c, 8'hee, 8'h12, 8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc,
      8'h25, 8'he0, 8'he1, 8'he2, 8'he3};
   logic [7:0] leg [21] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b,
      8'h0d, 8'hbd, 8'hed, 8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52,
      8'hd8, 8'h26, 8'hfa, 8'hfb, 8'hfc, 8'hfd};

   ////////////////////////////////////////////////////////////////////////
   // Core clock at 20 MHz and the decoder with its host.
   initial CORE_CLK = 1'b0;
   always #25 CORE_CLK = ~CORE_CLK;
   fead_host_model host (.sck(SCK), .ce_n(CE_N), .si(SI));
   fead_top dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SCK(SCK),
      .CE_N(CE_N), .SI(SI), .RD_NEXT(RD_NEXT), .CMD_VALID(CMD_VALID),
      .CMD_OPCODE(CMD_OPCODE), .CMD_CLASS(CMD_CLASS), .CMD_WIDE(CMD_WIDE),
      .CMD_ADDR(CMD_ADDR), .CMD_DROP(CMD_DROP), .RD_ADDR(RD_ADDR),
      .BANK_REG(BANK_REG), .WIDE_MODE(WIDE_MODE));

   // Prints the counts and the verdict, then stops.
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Cuts a hang short; the whole run needs about 1400 cycles.
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 8000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Expected class of an opcode.
   function automatic logic [2:0] cls(input logic [7:0] op);
      case (op)
         8'h13, 8'h0c, 8'h0e, 8'hbc, 8'h3c, 8'hbe, 8'hec, 8'h6c, 8'hee,
         8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd,
         8'hed: cls = 3'h1;
         8'h12, 8'h34, 8'h3e, 8'h02, 8'h32, 8'h38: cls = 3'h2;
         8'h21, 8'h5c, 8'hdc, 8'hd7, 8'h20, 8'h52, 8'hd8: cls = 3'h3;
         8'hb7, 8'he9, 8'h17: cls = 3'h5;
         default: cls = 3'h4;
      endcase
   endfunction

   // Sends one frame and judges the answer against the expectation.
   task automatic do_cmd(input logic [39:0] d, input int nb,
      input logic ev, input logic ew, input logic [31:0] ea);
      logic v;
      logic dr;
      int k;
      v = 1'b0;
      dr = 1'b0;
      host.send(d, nb);
      for (k = 0; k < 12 && v !== 1'b1 && dr !== 1'b1; k++) begin
         @(negedge CORE_CLK);
         v = CMD_VALID;
         dr = CMD_DROP;
      end
      repeat (3) @(negedge CORE_CLK);
      chk(v, ev);
      chk(dr, !ev);
      if (ev) begin
         chk(CMD_OPCODE, d[39:32]);
         chk(CMD_WIDE, ew);
         chk(CMD_ADDR, ea);
         chk(CMD_CLASS, cls(d[39:32]));
      end
   endtask

   // Holds the step request for n cycles.
   task automatic step(input int n);
      RD_NEXT = 1'b1;
      repeat (n) @(negedge CORE_CLK);
      RD_NEXT = 1'b0;
      @(negedge CORE_CLK);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_dedicated;
      foreach (ded[i]) begin
         do_cmd({ded[i], ADR}, 40, 1, 1, ADR);
         chk(CMD_WIDE, 1'b1);
      end
   endtask

   task automatic t_legacy;
      foreach (leg[i])
         do_cmd({leg[i], 32'h12345600}, 32, 1, 0, 32'h00123456);
      do_cmd({8'hfd, 32'h12345600}, 40, 1, 0, 32'h00123456);
      do_cmd({8'h52, 32'h12345600}, 32, 1, 0, 32'h00123456);
   endtask

   task automatic t_bank;
      do_cmd({8'h17, 32'h01000000}, 16, 1, 0, 0);
      chk(BANK_REG, 8'h01);
      do_cmd({8'h03, 32'habcdef00}, 32, 1, 0, 32'h01abcdef);
      do_cmd({8'h20, 32'h00100000}, 32, 1, 0, 32'h01001000);
      do_cmd({8'h02, 32'h00010000}, 32, 1, 0, 32'h01000100);
      do_cmd({8'h17, 32'hff000000}, 16, 1, 0, 0);
      chk(BANK_REG, 8'h81);
      do_cmd({8'h0b, 32'h00123456}, 40, 1, 1, 32'h00123456);
      do_cmd({8'hd8, 32'h12345600}, 32, 0, 0, 0);
      do_cmd({8'hb7, 32'h0}, 8, 1, 0, 0);
      chk(WIDE_MODE, 1'b0);
      do_cmd({8'h17, 32'h0}, 16, 1, 0, 0);
   endtask

   task automatic t_enter;
      do_cmd({8'hb7, 32'h0}, 8, 1, 0, 0);
      chk(WIDE_MODE, 1'b1);
      do_cmd({8'hfa, ADR}, 40, 1, 1, ADR);
      do_cmd({8'h03, 32'h12345600}, 32, 0, 0, 0);
      do_cmd({8'he9, 32'h0}, 8, 1, 0, 0);
      chk(WIDE_MODE, 1'b0);
   endtask

   task automatic t_misaligned;
      do_cmd({8'h17, 32'h01000000}, 12, 0, 0, 0);
      chk(BANK_REG, 8'h00);
      do_cmd({8'h03, 32'h12345600}, 39, 0, 0, 0);
   endtask

   task automatic t_stream;
      do_cmd({8'h03, 32'hffffff00}, 32, 1, 0, 32'h00ffffff);
      step(1);
      chk(RD_ADDR, 32'h01000000);
      chk(BANK_REG, 8'h00);
      do_cmd({8'h17, 32'h01000000}, 16, 1, 0, 0);
      do_cmd({8'h03, 32'hfffffe00}, 32, 1, 0, 32'h01fffffe);
      step(3);
      chk(RD_ADDR, 32'h01ffffff);
      chk(BANK_REG, 8'h01);
   endtask

   // Reset, then every scenario in turn.
   initial begin
      RD_NEXT = 1'b0;
      RESET_N = 1'b0;
      repeat (12) @(negedge CORE_CLK);
      RESET_N = 1'b1;
      @(negedge CORE_CLK);
      chk(BANK_REG, 8'h00);
      chk(WIDE_MODE, 1'b0);
      t_dedicated();
      t_legacy();
      t_bank();
      t_enter();
      t_misaligned();
      t_stream();
      end_sim();
   end
endmodule
`default_nettype wire
